/* File: common/asp_pkg.sv */
package asp_pkg;
	// Wishbone byte addresses
	localparam logic [3:0] ASP_CTRL_OFS = 4'h0;
	localparam logic [3:0] ASP_BUF_OFS = 4'h4;
	localparam logic [3:0] ASP_BAUD_OFS = 4'h8;

	// Control register field positions, and the baud doubler bit
	localparam int ASP_MODE_HI_BIT = 7;
	localparam int ASP_MODE_LO_BIT = 6;
	localparam int ASP_FILT_BIT = 5;
	localparam int ASP_REN_BIT = 4;
	localparam int ASP_TB9_BIT = 3;
	localparam int ASP_RB9_BIT = 2;
	localparam int ASP_TI_BIT = 1;
	localparam int ASP_RI_BIT = 0;
	localparam int ASP_DBL_BIT = 0;

	// Reset values
	localparam logic [7:0] ASP_CTRL_RST = 8'h00;
	localparam logic [7:0] ASP_BUF_RST = 8'h00;

	// Timing counts in core clock cycles
	localparam logic [1:0] ASP_TI_DELAY = 2'h2;
	localparam logic [1:0] ASP_M2_TICK_FAST = 2'h1;
	localparam logic [1:0] ASP_M2_TICK_SLOW = 2'h3;

	// Receive majority sample points within a bit
	localparam logic [3:0] ASP_SAMPLE_FIRST = 4'h7;
	localparam logic [3:0] ASP_SAMPLE_LAST = 4'h9;

	// Frame lengths in bits
	localparam logic [3:0] ASP_LEN_8BIT = 4'ha;
	localparam logic [3:0] ASP_LEN_9BIT = 4'hb;

	typedef enum logic [1:0] {
		ASP_MODE0 = 2'b00,
		ASP_MODE1 = 2'b01,
		ASP_MODE2 = 2'b10,
		ASP_MODE3 = 2'b11
	} asp_mode_t;

	typedef struct packed {
		asp_mode_t mode;
		logic filt;
		logic ren;
		logic tb9;
	} asp_cfg_t;
endpackage : asp_pkg

/* File: verilog/asp_port.sv */
`timescale 1ns/1ps
// What this block does
// R1: Mode 1 transmit starts at first divide-by-16 rollover after buffer write.
// R2: Mode 1 frame is start, eight data bits LSB first, stop.
// R3: Mode 1 transmit-complete flag sets two core cycles after stop bit.
// R4: With receive enabled, a falling edge on receive pin starts reception.
// R5: Receive pin is sampled sixteen times per bit at any rate.
// R6: Start edge resets receive divide-by-16 counter to align bit boundaries.
// R7: Each bit is the majority of three mid-bit samples.
// R8: Start bit not voted low abandons reception, waits for next edge.
// R9: Mode 1 accepts only if receive flag clear and, filtered, stop is one.
// R10: Accepted frame loads buffer, final bit into ninth-bit flag, sets flag.
// R11: Rejected frame leaves buffer and ninth-bit flag alone, flag unset.
// R12: After mid tenth bit (stop in mode 1, ninth bit in modes 2/3), receiver watches again for a falling edge.
// R13: Modes 2 and 3 send start, eight data, ninth bit, stop.
// R14: Mode 2 runs at core clock over 32 or 64 by baud doubler.
// R15: Mode 2 starts at first rollover, flags completion as stop is driven.
// R16: Mode 3 uses mode 2 framing with the mode 1 rate.
// R17: Modes 2/3 filtered: accept only when received ninth bit is one.
// R18: Remote master sends ninth bit one for address, zero for data.
// R19: Modes 1 and 3 divide timer overflows by 32, or by 16 with the baud doubler, for bit rate.
// R20: Mode bits 00, 01, 10, 11 select modes 0 to 3.
// R21: Completion flags are only cleared by firmware, never by hardware.
// R22: Transmit pin idles high; start is zero, stop is one.
module asp_port (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic timer_overflow,
	input wire logic receive_pin,
	output logic transmit_pin
);
	asp_pkg::asp_cfg_t cfg_q;
	logic baud_doubler_q;
	logic transmit_complete_flag_q;
	logic receive_complete_flag_q;
	logic received_ninth_bit_q;
	logic [7:0] serial_buffer_rx_q;
	logic [7:0] serial_buffer_tx_q;
	logic [31:0] dat_q;
	logic ack_q;
	logic wr_ctrl;
	logic wr_buf;
	logic wr_baud;
	logic [1:0] pre_q;
	logic ovf_half_q;
	logic tick;
	logic nine_bit;
	logic [3:0] frame_len;

	// Transmit state
	logic tx_pend_q;
	logic tx_busy_q;
	logic [3:0] tx_div_q;
	logic [3:0] tx_left_q;
	logic [10:0] tx_sh_q;
	logic [1:0] ti_dly_q;
	logic tx_txt_q;
	logic ti_set;
	logic tx_roll;

	// Receive state
	typedef enum logic [1:0] {
		ASP_RX_IDLE = 2'b00,
		ASP_RX_BITS = 2'b01
	} asp_rx_t;
	asp_rx_t rx_st_q;
	logic [3:0] rx_div_q;
	logic [3:0] rx_idx_q;
	logic [2:0] rx_smp_q;
	logic rx_prev_q;
	logic [8:0] rx_sh_q;
	logic rx_vote;
	logic rx_mid;
	logic rx_accept;
	logic rx_final;

	function automatic logic hit(input logic [3:0] ofs);
		hit = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0] &&
			wb_adr_i == ofs;
	endfunction : hit

	// Writes land on lane 0, at the edge where the master sees ack
	assign wr_ctrl = hit(asp_pkg::ASP_CTRL_OFS);
	assign wr_buf = hit(asp_pkg::ASP_BUF_OFS);
	assign wr_baud = hit(asp_pkg::ASP_BAUD_OFS);

	// Mode 2 and 3 carry a ninth bit
	assign nine_bit = cfg_q.mode[1]; // R13 R16 R20
	assign frame_len = nine_bit ? asp_pkg::ASP_LEN_9BIT :
		asp_pkg::ASP_LEN_8BIT;

	// Bus answer, one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
		end
	end

	// Read mux; unmapped addresses read as zero
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			dat_q <= 32'h0;
		end else begin
			unique case (wb_adr_i)
			asp_pkg::ASP_CTRL_OFS: dat_q <= {24'h0, cfg_q.mode, cfg_q.filt,
				cfg_q.ren, cfg_q.tb9, received_ninth_bit_q,
				transmit_complete_flag_q, receive_complete_flag_q};
			asp_pkg::ASP_BUF_OFS: dat_q <= {24'h0, serial_buffer_rx_q};
			asp_pkg::ASP_BAUD_OFS: dat_q <= {31'h0, baud_doubler_q};
			default: dat_q <= 32'h0;
			endcase
		end
	end
	assign wb_dat_o = dat_q;
	assign wb_ack_o = ack_q;

	// Configuration bits written by firmware
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_q <= asp_pkg::asp_cfg_t'(asp_pkg::ASP_CTRL_RST[7:3]);
			baud_doubler_q <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				cfg_q <= asp_pkg::asp_cfg_t'(wb_dat_i[7:3]);
			end
			if (wr_baud) begin
				baud_doubler_q <= wb_dat_i[asp_pkg::ASP_DBL_BIT];
			end
		end
	end

	// Sixteen-times tick: core prescale in mode 2, timer overflow in modes 1 and 3, none in mode 0
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pre_q <= 2'h0;
			ovf_half_q <= 1'b0;
		end else begin
			if (tick || cfg_q.mode != asp_pkg::ASP_MODE2) begin
				pre_q <= 2'h0;
			end else begin
				pre_q <= pre_q + 2'h1;
			end
			if (timer_overflow) begin
				ovf_half_q <= !ovf_half_q;
			end
		end
	end
	always_comb begin
		unique case (cfg_q.mode)
		asp_pkg::ASP_MODE2: tick = pre_q == (baud_doubler_q ?
			asp_pkg::ASP_M2_TICK_FAST : asp_pkg::ASP_M2_TICK_SLOW); // R14
		asp_pkg::ASP_MODE1, asp_pkg::ASP_MODE3: tick = timer_overflow &&
			(baud_doubler_q || ovf_half_q); // R19 R16
		default: tick = 1'b0;
		endcase
	end

	// Transmit divide-by-16 counter free-runs on the tick
	assign tx_roll = tick && tx_div_q == 4'hf; // R19
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			tx_div_q <= 4'h0;
		end else if (tick) begin
			tx_div_q <= tx_div_q + 4'h1;
		end
	end

	// Holding buffer for the byte to send
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			serial_buffer_tx_q <= asp_pkg::ASP_BUF_RST;
		end else if (wr_buf) begin
			serial_buffer_tx_q <= wb_dat_i[7:0];
		end
	end

	// Transmit shifter; a write during a frame waits for the next one
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			tx_pend_q <= 1'b0;
			tx_busy_q <= 1'b0;
			tx_left_q <= 4'h0;
			tx_sh_q <= 11'h7ff;
			ti_dly_q <= 2'h0;
			tx_txt_q <= 1'b0;
		end else begin
			tx_txt_q <= 1'b0;
			if (ti_dly_q != 2'h0) begin
				ti_dly_q <= ti_dly_q - 2'h1;
			end
			if (wr_buf) begin
				tx_pend_q <= 1'b1;
			end
			if (tx_roll && !tx_busy_q && tx_pend_q && !wr_buf) begin
				tx_pend_q <= 1'b0; // R1 R15
				tx_busy_q <= 1'b1;
				tx_left_q <= frame_len;
				tx_sh_q <= {1'b1, nine_bit ? cfg_q.tb9 : 1'b1,
					serial_buffer_tx_q, 1'b0}; // R2 R13 R22
			end else if (tx_roll && tx_busy_q) begin
				tx_sh_q <= {1'b1, tx_sh_q[10:1]};
				tx_left_q <= tx_left_q - 4'h1;
				if (tx_left_q == 4'h1) begin
					tx_busy_q <= 1'b0;
					if (!nine_bit) begin
						ti_dly_q <= asp_pkg::ASP_TI_DELAY; // R3
					end
				end else if (tx_left_q == 4'h2 && nine_bit) begin
					tx_txt_q <= 1'b1; // R15
				end
			end
		end
	end
	assign ti_set = tx_txt_q || ti_dly_q == 2'h1; // R3

	// Pin driven from the shifter's low bit, high when idle
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			transmit_pin <= 1'b1;
		end else begin
			transmit_pin <= tx_sh_q[0]; // R22
		end
	end

	// Majority of three mid-bit samples
	assign rx_vote = (rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[0] & rx_smp_q[2]) |
		(rx_smp_q[1] & rx_smp_q[2]); // R7
	assign rx_mid = tick && rx_div_q == asp_pkg::ASP_SAMPLE_LAST + 4'h1;
	// Decide at the tenth bit: stop in mode 1, ninth bit in modes 2/3
	assign rx_final = rx_mid && rx_idx_q == asp_pkg::ASP_LEN_8BIT - 4'h1;
	assign rx_accept = rx_final && !receive_complete_flag_q &&
		(!cfg_q.filt || rx_vote); // R9 R17

	// Receive sequencer
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rx_st_q <= ASP_RX_IDLE;
			rx_div_q <= 4'h0;
			rx_idx_q <= 4'h0;
			rx_smp_q <= 3'h7;
			rx_prev_q <= 1'b1;
			rx_sh_q <= 9'h0;
		end else if (tick) begin
			rx_prev_q <= receive_pin; // R5
			unique case (rx_st_q)
			ASP_RX_IDLE: begin
				if (cfg_q.ren && rx_prev_q && !receive_pin) begin
					rx_st_q <= ASP_RX_BITS; // R4
					rx_div_q <= 4'h1; // R6
					rx_idx_q <= 4'h0;
				end
			end
			ASP_RX_BITS: begin
				rx_div_q <= rx_div_q + 4'h1;
				if (rx_div_q >= asp_pkg::ASP_SAMPLE_FIRST &&
					rx_div_q <= asp_pkg::ASP_SAMPLE_LAST) begin
					rx_smp_q <= {receive_pin, rx_smp_q[2:1]}; // R5 R7
				end
				if (rx_div_q == 4'hf) begin
					rx_idx_q <= rx_idx_q + 4'h1;
				end
				if (rx_mid && rx_idx_q == 4'h0 && rx_vote) begin
					rx_st_q <= ASP_RX_IDLE; // R8
				end else if (rx_final) begin
					rx_st_q <= ASP_RX_IDLE; // R12
				end else if (rx_mid) begin
					rx_sh_q <= {rx_vote, rx_sh_q[8:1]};
				end
			end
			default: rx_st_q <= ASP_RX_IDLE;
			endcase
		end
	end

	// Receive buffer loads only on acceptance; ninth bit on acceptance or a control write
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			serial_buffer_rx_q <= asp_pkg::ASP_BUF_RST;
			received_ninth_bit_q <= 1'b0;
		end else if (rx_accept) begin
			serial_buffer_rx_q <= rx_sh_q[8:1]; // R10
			received_ninth_bit_q <= rx_vote; // R10 R11
		end else if (wr_ctrl) begin
			received_ninth_bit_q <= wb_dat_i[asp_pkg::ASP_RB9_BIT];
		end
	end

	// Flags: hardware set wins over a firmware write in the same cycle
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			transmit_complete_flag_q <= 1'b0;
			receive_complete_flag_q <= 1'b0;
		end else begin
			if (ti_set) begin
				transmit_complete_flag_q <= 1'b1;
			end else if (wr_ctrl) begin
				transmit_complete_flag_q <= wb_dat_i[asp_pkg::ASP_TI_BIT]; // R21
			end
			if (rx_accept) begin
				receive_complete_flag_q <= 1'b1; // R10
			end else if (wr_ctrl) begin
				receive_complete_flag_q <= wb_dat_i[asp_pkg::ASP_RI_BIT]; // R21
			end
		end
	end
endmodule : asp_port

/* File: dv/asp_port_sva.sv */
`timescale 1ns/1ps
module asp_port_sva (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic transmit_pin
);
	default clocking dc @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic rd_c, wr_c, rd_b, bv_ok_q;
	logic [2:0] fl_q;
	logic [7:0] bv_q;
	// Acked accesses; master still holds the address
	assign rd_c = wb_ack_o && !wb_we_i && wb_adr_i == asp_pkg::ASP_CTRL_OFS;
	assign wr_c = wb_ack_o && wb_we_i && wb_adr_i == asp_pkg::ASP_CTRL_OFS;
	assign rd_b = wb_ack_o && !wb_we_i && wb_adr_i == asp_pkg::ASP_BUF_OFS;
	// Flags last read; any control write forgets them
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) fl_q <= 3'h0;
		else if (wr_c) fl_q <= 3'h0;
		else if (rd_c) fl_q <= wb_dat_o[2:0];
	end
	// Buffer is frozen once a held frame was seen
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) bv_ok_q <= 1'b0;
		else if (wr_c) bv_ok_q <= 1'b0;
		else if (rd_b && fl_q[0]) bv_ok_q <= 1'b1;
	end
	// Data only, qualified by bv_ok_q
	always_ff @(posedge clk_sys) begin
		if (rd_b) bv_q <= wb_dat_o[7:0];
	end
	property p_ack_next;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_once;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_once: assert property (p_ack_once) else $error("ack held");
	property p_tx_idle;
		$fell(sys_rst) |-> transmit_pin ##1 transmit_pin;
	endproperty
	a_tx_idle: assert property (p_tx_idle) else $error("tx low");
	// A bit lasts 16 ticks, never under 16 clocks
	property p_tx_hold;
		$changed(transmit_pin) |=>
			$stable(transmit_pin)[*8] ##1 $stable(transmit_pin)[*7];
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("short bit");
	property p_ti_kept;
		rd_c && fl_q[1] |-> wb_dat_o[1];
	endproperty
	a_ti_kept: assert property (p_ti_kept) else $error("tx flag lost");
	property p_ri_kept;
		rd_c && fl_q[0] |-> wb_dat_o[0];
	endproperty
	a_ri_kept: assert property (p_ri_kept) else $error("rx flag lost");
	property p_b9_kept;
		rd_c && fl_q[0] |-> wb_dat_o[2] == fl_q[2];
	endproperty
	a_b9_kept: assert property (p_b9_kept) else $error("ninth moved");
	property p_buf_kept;
		rd_b && bv_ok_q |-> wb_dat_o[7:0] == bv_q;
	endproperty
	a_buf_kept: assert property (p_buf_kept) else $error("buf moved");
	c_rx: cover property (rd_c && wb_dat_o[0]);
	c_tx: cover property ($fell(transmit_pin));
	c_wr: cover property (wb_ack_o && wb_we_i);
endmodule : asp_port_sva
bind asp_port asp_port_sva u_asp_port_sva (
	.clk_sys(clk_sys),
	.sys_rst(sys_rst),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.transmit_pin(transmit_pin)
);

/* File: dv/asp_node.sv */
`timescale 1ns/1ps
module asp_node (
	input wire logic clk_sys,
	input wire logic transmit_pin,
	output logic receive_pin
);
	initial receive_pin = 1'b1;
	// LSB first, w clocks a bit, then mark level
	task send(input logic [10:0] f, input int n, input int w);
		for (int i = 0; i < n; i++) begin
			receive_pin <= f[i];
			repeat (w) @(posedge clk_sys);
		end
		receive_pin <= 1'b1;
		@(posedge clk_sys);
	endtask : send
	// Mid-bit sampling tolerates edge jitter; w clocks a bit
	task grab(output logic [10:0] f, input int n, input int w);
		f = 11'h0;
		while (transmit_pin !== 1'b0) @(posedge clk_sys);
		repeat (w / 2) @(posedge clk_sys);
		for (int i = 0; i < n; i++) begin
			f[i] = transmit_pin;
			repeat (w) @(posedge clk_sys);
		end
	endtask : grab
endmodule : asp_node

/* File: dv/asp_port_bench.sv */
`timescale 1ns/1ps
module asp_port_bench;
	typedef struct packed {
		logic [7:0] ctrl;
		logic [10:0] f;
		logic [3:0] n;
	} asp_row_t;
	logic clk_sys, sys_rst, cyc, stb, we, tov, rx, tx, ack;
	logic [3:0] adr;
	logic [31:0] dat, q, dat_o;
	logic [10:0] f;
	int fails, check_count, cycles;
	asp_row_t rows [3];
	asp_port u_asp_port (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.wb_cyc_i(cyc),
		.wb_stb_i(stb),
		.wb_we_i(we),
		.wb_adr_i(adr),
		.wb_sel_i(4'hf),
		.wb_dat_i(dat),
		.wb_dat_o(dat_o),
		.wb_ack_o(ack),
		.timer_overflow(tov),
		.receive_pin(rx),
		.transmit_pin(tx)
	);
	asp_node u_asp_node (
		.clk_sys(clk_sys),
		.transmit_pin(tx),
		.receive_pin(rx)
	);
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	// One classic cycle; request held until ack is seen
	task wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= {24'h0, d};
		do @(posedge clk_sys); while (ack !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task end_sim();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_sim
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// Overflow every other clock gives a 32-clock bit with the doubler, 64 without
	always @(posedge clk_sys) begin
		tov <= ~tov;
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		{sys_rst, cyc, stb, we, tov, adr, dat} = {5'h10, 4'h0, 32'h0};
		rows[0] = '{8'h50, 11'h34a, 4'ha};
		rows[1] = '{8'h98, 11'h678, 4'hb};
		rows[2] = '{8'hd0, 11'h5fe, 4'hb};
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		chk("tx idle", 32'h1, {31'h0, tx});
		wb(1'b0, asp_pkg::ASP_CTRL_OFS, 8'h0);
		chk("ctrl", {24'h0, asp_pkg::ASP_CTRL_RST}, q);
		wb(1'b0, asp_pkg::ASP_BUF_OFS, 8'h0);
		chk("buf", {24'h0, asp_pkg::ASP_BUF_RST}, q);
		wb(1'b0, 4'hc, 8'h0);
		chk("unmapped", 32'h0, q);
		wb(1'b1, asp_pkg::ASP_BAUD_OFS, 8'h01);
		// Modes 1 to 3: send a byte out, then take it back in
		foreach (rows[i]) begin
			wb(1'b1, asp_pkg::ASP_CTRL_OFS, rows[i].ctrl);
			wb(1'b1, asp_pkg::ASP_BUF_OFS, rows[i].f[8:1]);
			u_asp_node.grab(f, rows[i].n, 32);
			chk("frame", {21'h0, rows[i].f}, {21'h0, f});
			wb(1'b0, asp_pkg::ASP_CTRL_OFS, 8'h0);
			chk("ti", {24'h0, rows[i].ctrl | 8'h2}, q & 32'hfb);
			u_asp_node.send(rows[i].f, rows[i].n, 32);
			wb(1'b0, asp_pkg::ASP_BUF_OFS, 8'h0);
			chk("rx", {24'h0, rows[i].f[8:1]}, q);
			wb(1'b0, asp_pkg::ASP_CTRL_OFS, 8'h0);
			chk("flags", {24'h0, rows[i].ctrl | {5'h0, rows[i].f[9], 2'h3}},
				q);
		end
		// Second frame while the first is still flagged
		wb(1'b1, asp_pkg::ASP_CTRL_OFS, 8'h50);
		u_asp_node.send(11'h222, 10, 32);
		wb(1'b0, asp_pkg::ASP_CTRL_OFS, 8'h0);
		chk("held", 32'h55, q);
		wb(1'b0, asp_pkg::ASP_BUF_OFS, 8'h0);
		u_asp_node.send(11'h244, 10, 32);
		wb(1'b0, asp_pkg::ASP_CTRL_OFS, 8'h0);
		chk("still held", 32'h55, q);
		wb(1'b0, asp_pkg::ASP_BUF_OFS, 8'h0);
		chk("kept", 32'h11, q);
		// Filtered mode 1 with a low stop bit
		wb(1'b1, asp_pkg::ASP_CTRL_OFS, 8'h70);
		u_asp_node.send(11'h0aa, 10, 32);
		wb(1'b0, asp_pkg::ASP_CTRL_OFS, 8'h0);
		chk("bad stop", 32'h0, {31'h0, q[0]});
		// Glitch, data byte, then address byte
		wb(1'b1, asp_pkg::ASP_CTRL_OFS, 8'hf0);
		u_asp_node.send(11'h0, 1, 4);
		repeat (64) @(posedge clk_sys);
		u_asp_node.send(11'h4cc, 11, 32);
		u_asp_node.send(11'h6b4, 11, 32);
		wb(1'b0, asp_pkg::ASP_BUF_OFS, 8'h0);
		chk("addr", 32'h5a, q);
		wb(1'b0, asp_pkg::ASP_CTRL_OFS, 8'h0);
		chk("addr flags", 32'hf5, q);
		// Half rate without the doubler: mode 2 out, mode 3 in
		wb(1'b1, asp_pkg::ASP_BAUD_OFS, 8'h00);
		wb(1'b1, asp_pkg::ASP_CTRL_OFS, 8'h98);
		wb(1'b1, asp_pkg::ASP_BUF_OFS, 8'h3c);
		u_asp_node.grab(f, 11, 64);
		chk("slow frame", 32'h678, {21'h0, f});
		wb(1'b1, asp_pkg::ASP_CTRL_OFS, 8'hd8);
		u_asp_node.send(11'h678, 11, 64);
		wb(1'b0, asp_pkg::ASP_BUF_OFS, 8'h0);
		chk("slow rx", 32'h3c, q);
		// Reset in mid-frame: pin back to idle, registers cleared
		wb(1'b1, asp_pkg::ASP_BUF_OFS, 8'h0f);
		repeat (96) @(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		@(posedge clk_sys);
		chk("rst tx", 32'h1, {31'h0, tx});
		wb(1'b0, asp_pkg::ASP_CTRL_OFS, 8'h0);
		chk("rst ctrl", {24'h0, asp_pkg::ASP_CTRL_RST}, q);
		wb(1'b0, asp_pkg::ASP_BUF_OFS, 8'h0);
		chk("rst buf", {24'h0, asp_pkg::ASP_BUF_RST}, q);
		end_sim();
	end
endmodule : asp_port_bench
